// File: hdl/can_bias_ctrl.sv
/*
 * bus-bias state machine, local and remote wake detection, driver and
 * receiver gating of a high-speed bus transceiver.
 * assumes all inputs except WAKE_I synchronous to MCLK_I; the operating mode and the
 * supply flags come from surrounding logic; bus level is a digital
 * dominant indication from the receiver comparator.
 */
// Overview of operation
// - either edge on the wake pin registers one local wake event
// - local wake detection is enabled in sleep mode
// - no local or remote wake detection in normal or silent mode
// - bias logic has four states: off, auto inactive, auto active, active
// - battery falling undervoltage forces off state, bus floating
// - off moves to auto inactive once battery rises above threshold
// - remote wake in low-power mode moves auto inactive to auto active
// - silence timeout in low-power mode returns auto active to inactive
// - leaving normal/silent picks auto active if bus recently busy
// - entering normal/silent with core or io undervoltage gives auto active
// - normal mode, or silent mode once active, means active state, bias at half core supply
// - active entered only on normal mode with both supplies good
// - transmit low before leaving standby blocks driver and receiver
// - silent mode: driver off, receiver still reports bus
// - normal mode: low transmit drives dominant, high leaves bus released
// - auto inactive biases both bus pins to ground
// - standby: receive output high, low only while wake pending
// - remote wake needs dominant, recessive, dominant each past filter time
// - dominant is logic low on transmit and receive, recessive high
`timescale 1ns/1ps
`default_nettype none
`include "can_bias_map.svh"
module can_bias_ctrl #(
	parameter int FILTER_CYCLES  = `WAKE_FILTER_CYCLES,
	parameter int SILENCE_CYCLES = `BUS_SILENCE_CYCLES,
	parameter int DEGLITCH       = `WAKE_DEGLITCH_CYCLES,
	parameter int FIFO_DEPTH     = 32
) (
	// clock and reset
	input  wire logic                   MCLK_I,
	input  wire logic                   RST_I,
	// operating mode and supplies
	input  wire can_bias_pkg::op_mode_e MODE_I,
	input  wire can_bias_pkg::supply_s  SUPPLY_I,
	// controller pins
	input  wire logic                   TXD_I,
	output logic                        RXD_O,
	output logic                        RXD_READY_O,
	input  wire logic                   RXD_ACCEPT_I,
	// bus side
	input  wire logic                   BUS_DOMINANT_I,
	output can_bias_pkg::bus_drive_s    BUS_DRIVE_O,
	// wake
	input  wire logic                   WAKE_I,
	input  wire logic                   WAKE_CLEAR_I,
	output logic                        WAKE_PENDING_O,
	output logic                        LOCAL_WAKE_EVENT_O,
	output logic                        REMOTE_WAKE_PATTERN_O,
	// status
	output can_bias_pkg::bias_state_e   BIAS_STATE_O,
	output logic                        TRANSMIT_STUCK_LOW_BLOCK_O
);
	localparam int FW = $clog2(FILTER_CYCLES + 1);
	localparam int SW = $clog2(SILENCE_CYCLES + 1);

	can_bias_pkg::bias_state_e bias;
	can_bias_pkg::bias_state_e next_bias;
	can_bias_pkg::op_mode_e    mode_q;
	typedef enum logic [1:0] {
		PAT_IDLE,
		PAT_DOM1,
		PAT_REC,
		PAT_DOM2
	} pat_e;
	pat_e                      pat;

	logic                      active_mode;
	logic                      low_power;
	logic [1:0]                wake_sync;
	logic [DEGLITCH+2:0]       wake_fill;
	logic [DEGLITCH-1:0]       wake_hist;
	logic                      wake_level;
	logic                      local_wake_event;
	logic [FW-1:0]             filt_cnt;
	logic                      filt_level;
	logic                      filt_done;
	logic                      remote_wake_pattern;
	logic [SW-1:0]             idle_cnt;
	logic                      silence_expired;
	logic                      tx_low_seen;
	logic                      stuck_block;
	logic                      wake_pending;
	logic                      rx_bit;
	logic                      fifo_out_valid;
	logic                      fifo_out_data;
	logic                      fifo_in_ready;

	assign active_mode = (MODE_I == can_bias_pkg::MODE_NORMAL) ||
		(MODE_I == can_bias_pkg::MODE_SILENT);
	assign low_power   = !active_mode;

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			mode_q <= can_bias_pkg::MODE_STANDBY;
		end else begin
			mode_q <= MODE_I;
		end
	end

	// =================================================================
	// local wake: sync, deglitch, edge detect
	// =================================================================
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			wake_sync  <= 2'h0;
			wake_hist  <= '0;
			wake_fill  <= '0;
			wake_level <= 1'b0;
			local_wake_event <= 1'b0;
		end else begin
			wake_sync <= {wake_sync[0], WAKE_I};
			wake_hist <= {wake_hist[DEGLITCH-2:0], wake_sync[1]};
			// no edge until the pipeline holds real pin samples after reset
			wake_fill <= {wake_fill[DEGLITCH+1:0], 1'b1};
			local_wake_event <= 1'b0;
			if (wake_hist == '1 || wake_hist == '0) begin
				wake_level <= wake_hist[0];
				// either edge counts, only in sleep mode
				if (wake_fill[DEGLITCH+2] && wake_level != wake_hist[0] &&
					MODE_I == can_bias_pkg::MODE_SLEEP) begin
					local_wake_event <= 1'b1;
				end
			end
		end
	end

	// =================================================================
	// remote wake pattern filter
	// =================================================================
	assign filt_done = (filt_cnt == FW'(FILTER_CYCLES));

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			filt_cnt   <= '0;
			filt_level <= 1'b0;
		end else if (BUS_DOMINANT_I != filt_level) begin
			filt_level <= BUS_DOMINANT_I;
			filt_cnt   <= '0;
		end else if (!filt_done) begin
			filt_cnt <= filt_cnt + 1'b1;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			pat <= PAT_IDLE;
			remote_wake_pattern <= 1'b0;
		end else begin
			remote_wake_pattern <= 1'b0;
			if (active_mode || bias == can_bias_pkg::BIAS_OFF) begin
				pat <= PAT_IDLE;
			end else begin
				case (pat)
					PAT_IDLE: begin
						if (filt_done && filt_level) begin
							pat <= PAT_DOM1;
						end
					end
					PAT_DOM1: begin
						if (filt_done && !filt_level) begin
							pat <= PAT_REC;
						end
					end
					PAT_REC: begin
						if (filt_done && filt_level) begin
							pat <= PAT_DOM2;
							remote_wake_pattern <= 1'b1;
						end
					end
					default: begin
						// wait for recessive before a new pattern
						if (filt_done && !filt_level) begin
							pat <= PAT_IDLE;
						end
					end
				endcase
			end
		end
	end

	// =================================================================
	// bus silence timer
	// =================================================================
	assign silence_expired = (idle_cnt == SW'(SILENCE_CYCLES));

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			idle_cnt <= '0;
		end else if (BUS_DOMINANT_I) begin
			idle_cnt <= '0;
		end else if (!silence_expired) begin
			idle_cnt <= idle_cnt + 1'b1;
		end
	end

	// =================================================================
	// bias state machine
	// =================================================================
	always_comb begin
		next_bias = bias;
		case (bias)
			can_bias_pkg::BIAS_OFF: begin
				if (SUPPLY_I.battery_undervoltage_rise) begin
					next_bias = can_bias_pkg::BIAS_AUTO_INACTIVE;
				end
			end
			can_bias_pkg::BIAS_AUTO_INACTIVE: begin
				if (MODE_I == can_bias_pkg::MODE_NORMAL &&
					SUPPLY_I.core_above_rise && SUPPLY_I.io_above_rise) begin
					next_bias = can_bias_pkg::BIAS_ACTIVE;
				end else if (active_mode) begin
					next_bias = can_bias_pkg::BIAS_AUTO_ACTIVE;
				end else if (remote_wake_pattern) begin
					next_bias = can_bias_pkg::BIAS_AUTO_ACTIVE;
				end
			end
			can_bias_pkg::BIAS_AUTO_ACTIVE: begin
				if (MODE_I == can_bias_pkg::MODE_NORMAL &&
					SUPPLY_I.core_above_rise && SUPPLY_I.io_above_rise) begin
					next_bias = can_bias_pkg::BIAS_ACTIVE;
				end else if (low_power && silence_expired) begin
					next_bias = can_bias_pkg::BIAS_AUTO_INACTIVE;
				end
			end
			default: begin
				if (SUPPLY_I.core_undervoltage_fall || SUPPLY_I.io_undervoltage_fall) begin
					next_bias = can_bias_pkg::BIAS_AUTO_ACTIVE;
				end else if (low_power) begin
					next_bias = silence_expired ? can_bias_pkg::BIAS_AUTO_INACTIVE
						: can_bias_pkg::BIAS_AUTO_ACTIVE;
				end
			end
		endcase
		if (SUPPLY_I.battery_undervoltage_fall) begin
			next_bias = can_bias_pkg::BIAS_OFF;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			bias <= can_bias_pkg::BIAS_OFF;
		end else begin
			bias <= next_bias;
		end
	end

	// =================================================================
	// transmit stuck-low blocking
	// =================================================================
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			tx_low_seen <= 1'b0;
			stuck_block <= 1'b0;
		end else begin
			// low transmit seen in the last standby cycle before leaving it
			tx_low_seen <= (mode_q == can_bias_pkg::MODE_STANDBY) && !TXD_I;
			if (next_bias == can_bias_pkg::BIAS_ACTIVE &&
				bias != can_bias_pkg::BIAS_ACTIVE && tx_low_seen) begin
				stuck_block <= 1'b1;
			end else if (TXD_I || next_bias != can_bias_pkg::BIAS_ACTIVE) begin
				stuck_block <= 1'b0;
			end
		end
	end

	// =================================================================
	// wake pending flag
	// =================================================================
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			wake_pending <= 1'b0;
		end else if (local_wake_event || remote_wake_pattern) begin
			wake_pending <= 1'b1;
		end else if (WAKE_CLEAR_I || MODE_I == can_bias_pkg::MODE_NORMAL) begin
			wake_pending <= 1'b0;
		end
	end

	// =================================================================
	// receive path through the FIFO
	// =================================================================
	always_comb begin
		if (active_mode && bias == can_bias_pkg::BIAS_ACTIVE && !stuck_block) begin
			rx_bit = !BUS_DOMINANT_I;
		end else begin
			rx_bit = !wake_pending;
		end
	end

	can_bias_fifo #(
		.WIDTH (1),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i       (MCLK_I),
		.rst_i       (RST_I),
		.in_valid_i  (1'b1),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (rx_bit),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (RXD_ACCEPT_I),
		.out_data_o  (fifo_out_data)
	);

	// =================================================================
	// registered outputs
	// =================================================================
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			RXD_O       <= `RXD_RESET;
			RXD_READY_O <= 1'b0;
		end else begin
			RXD_READY_O <= fifo_out_valid;
			if (fifo_out_valid && RXD_ACCEPT_I) begin
				RXD_O <= fifo_out_data;
			end
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			BUS_DRIVE_O <= '0;
		end else begin
			BUS_DRIVE_O.drive_dominant <= (MODE_I == can_bias_pkg::MODE_NORMAL) &&
				(next_bias == can_bias_pkg::BIAS_ACTIVE) && !TXD_I &&
				!stuck_block &&
				!(tx_low_seen && bias != can_bias_pkg::BIAS_ACTIVE);
			BUS_DRIVE_O.bias_mid <= (next_bias == can_bias_pkg::BIAS_ACTIVE) ||
				(next_bias == can_bias_pkg::BIAS_AUTO_ACTIVE);
			BUS_DRIVE_O.bias_ground <= (next_bias == can_bias_pkg::BIAS_AUTO_INACTIVE);
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			WAKE_PENDING_O             <= 1'b0;
			LOCAL_WAKE_EVENT_O         <= 1'b0;
			REMOTE_WAKE_PATTERN_O      <= 1'b0;
			BIAS_STATE_O               <= can_bias_pkg::BIAS_OFF;
			TRANSMIT_STUCK_LOW_BLOCK_O <= 1'b0;
		end else begin
			WAKE_PENDING_O             <= wake_pending;
			LOCAL_WAKE_EVENT_O         <= local_wake_event;
			REMOTE_WAKE_PATTERN_O      <= remote_wake_pattern;
			BIAS_STATE_O               <= bias;
			TRANSMIT_STUCK_LOW_BLOCK_O <= stuck_block;
		end
	end
endmodule
`default_nettype wire

// File: common/can_bias_map.svh
/*
 * timing constants for the bus-bias and local wake block.
 * assumes a 100 MHz clock; long counts are top-level parameters.
 */
`ifndef CAN_BIAS_MAP_SVH
`define CAN_BIAS_MAP_SVH

// =====================================================================
// clock and timing
// =====================================================================
`define CLK_PERIOD_NS          10
`define WAKE_DEGLITCH_CYCLES   4
`define WAKE_FILTER_TIME_NS    1000
`define WAKE_FILTER_CYCLES     ((`WAKE_FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUS_SILENCE_TIME_US    900000
`define BUS_SILENCE_CYCLES     (`BUS_SILENCE_TIME_US * 1000 / `CLK_PERIOD_NS)

// =====================================================================
// reset values
// =====================================================================
`define RXD_RESET              1'b1

`endif

// File: common/can_bias_pkg.sv
/*
 * types for the bus-bias and local wake block.
 * assumes nothing beyond the map header.
 */
`default_nettype none
package can_bias_pkg;
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_SILENT,
		MODE_STANDBY,
		MODE_GOTOSLEEP,
		MODE_SLEEP
	} op_mode_e;

	typedef enum logic [1:0] {
		BIAS_OFF,
		BIAS_AUTO_INACTIVE,
		BIAS_AUTO_ACTIVE,
		BIAS_ACTIVE
	} bias_state_e;

	typedef struct packed {
		logic battery_undervoltage_fall;
		logic battery_undervoltage_rise;
		logic core_undervoltage_fall;
		logic io_undervoltage_fall;
		logic core_above_rise;
		logic io_above_rise;
	} supply_s;

	typedef struct packed {
		logic drive_dominant;
		logic bias_mid;
		logic bias_ground;
	} bus_drive_s;
endpackage
`default_nettype wire

// File: hdl/can_bias_fifo.sv
/*
 * small flip-flop FIFO with valid and ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module can_bias_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// File: bench/can_ctrl_model.sv
/*
 * model of the protocol controller on the transmit and receive pins.
 * assumes the bench asks for dominant bits and for drain stalls.
 */
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_model (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// bench control
	input  wire logic dom_req_i,
	input  wire logic stall_i,
	// transceiver pins
	output logic      txd_o = 1'b1,
	output logic      accept_o = 1'b0
);
	// dominant leaves as a low level, recessive as high
	always @(negedge clk_i) begin
		txd_o    <= rst_i | ~dom_req_i;
		accept_o <= ~rst_i & ~stall_i;
	end
endmodule
`default_nettype wire

// File: bench/can_bias_assertions.sv
/*
 * concurrent checks on the bus-bias block, bound to every instance.
 * assumes only the ports of can_bias_ctrl.
 */
`timescale 1ns/1ps
`default_nettype none
module can_bias_assertions (
	// clock and reset
	input wire logic                      MCLK_I,
	input wire logic                      RST_I,
	// inputs
	input wire can_bias_pkg::op_mode_e    MODE_I,
	input wire can_bias_pkg::supply_s     SUPPLY_I,
	input wire logic                      TXD_I,
	input wire logic                      WAKE_I,
	// outputs
	input wire can_bias_pkg::bus_drive_s  BUS_DRIVE_O,
	input wire logic                      LOCAL_WAKE_EVENT_O,
	input wire logic                      REMOTE_WAKE_PATTERN_O,
	input wire can_bias_pkg::bias_state_e BIAS_STATE_O,
	input wire logic                      TRANSMIT_STUCK_LOW_BLOCK_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	logic [3:0] link_cnt;
	logic       link;
	assign link = MODE_I == can_bias_pkg::MODE_NORMAL || MODE_I == can_bias_pkg::MODE_SILENT;
	// counts cycles spent in normal or silent mode
	always_ff @(posedge MCLK_I) begin
		if (RST_I || !link)
			link_cnt <= 4'h0;
		else if (link_cnt != 4'hf)
			link_cnt <= link_cnt + 4'h1;
	end
	property p_batt_off;
		SUPPLY_I.battery_undervoltage_fall |-> ##[1:3] BIAS_STATE_O == can_bias_pkg::BIAS_OFF;
	endproperty
	a_batt_off: assert property (p_batt_off) else $error("bias not off");
	property p_off_rise;
		BIAS_STATE_O == can_bias_pkg::BIAS_OFF && SUPPLY_I.battery_undervoltage_rise
		&& !SUPPLY_I.battery_undervoltage_fall |-> ##[1:3] BIAS_STATE_O == can_bias_pkg::BIAS_AUTO_INACTIVE;
	endproperty
	a_off_rise: assert property (p_off_rise) else $error("off not left");
	property p_active_entry;
		BIAS_STATE_O == can_bias_pkg::BIAS_ACTIVE && $past(BIAS_STATE_O) != can_bias_pkg::BIAS_ACTIVE
		|-> $past(MODE_I, 2) == can_bias_pkg::MODE_NORMAL && $past(SUPPLY_I.core_above_rise, 2);
	endproperty
	a_active_entry: assert property (p_active_entry) else $error("bad active entry");
	property p_core_uv;
		BIAS_STATE_O == can_bias_pkg::BIAS_ACTIVE && SUPPLY_I.core_undervoltage_fall
		&& !SUPPLY_I.battery_undervoltage_fall |-> ##[1:3] BIAS_STATE_O == can_bias_pkg::BIAS_AUTO_ACTIVE;
	endproperty
	a_core_uv: assert property (p_core_uv) else $error("active kept in undervoltage");
	property p_silent_drv;
		MODE_I == can_bias_pkg::MODE_SILENT || TXD_I |=> !BUS_DRIVE_O.drive_dominant;
	endproperty
	a_silent_drv: assert property (p_silent_drv) else $error("bus driven");
	property p_normal_drv;
		MODE_I == can_bias_pkg::MODE_NORMAL && BIAS_STATE_O == can_bias_pkg::BIAS_ACTIVE
		&& $past(BIAS_STATE_O, 2) == can_bias_pkg::BIAS_ACTIVE && !TRANSMIT_STUCK_LOW_BLOCK_O
		&& !TXD_I && !SUPPLY_I.core_undervoltage_fall && !SUPPLY_I.io_undervoltage_fall
		&& !SUPPLY_I.battery_undervoltage_fall
		|=> BUS_DRIVE_O.drive_dominant;
	endproperty
	a_normal_drv: assert property (p_normal_drv) else $error("dominant not driven");
	property p_inact_gnd;
		BIAS_STATE_O == can_bias_pkg::BIAS_AUTO_INACTIVE
		|-> $past(BUS_DRIVE_O.bias_ground) && !$past(BUS_DRIVE_O.bias_mid);
	endproperty
	a_inact_gnd: assert property (p_inact_gnd) else $error("inactive not grounded");
	property p_no_wake;
		link_cnt > 4'hb |-> !LOCAL_WAKE_EVENT_O && !REMOTE_WAKE_PATTERN_O;
	endproperty
	a_no_wake: assert property (p_no_wake) else $error("wake in link mode");
	property p_wake_pulse;
		MODE_I == can_bias_pkg::MODE_SLEEP && $changed(WAKE_I) |-> ##[3:12] LOCAL_WAKE_EVENT_O;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("no local wake");
	c_active: cover property (BIAS_STATE_O == can_bias_pkg::BIAS_ACTIVE);
	c_remote: cover property (REMOTE_WAKE_PATTERN_O);
	c_block: cover property (TRANSMIT_STUCK_LOW_BLOCK_O);
endmodule
bind can_bias_ctrl can_bias_assertions can_bias_assertions_i (
	.MCLK_I(MCLK_I), .RST_I(RST_I), .MODE_I(MODE_I), .SUPPLY_I(SUPPLY_I), .TXD_I(TXD_I),
	.WAKE_I(WAKE_I), .BUS_DRIVE_O(BUS_DRIVE_O), .LOCAL_WAKE_EVENT_O(LOCAL_WAKE_EVENT_O),
	.REMOTE_WAKE_PATTERN_O(REMOTE_WAKE_PATTERN_O), .BIAS_STATE_O(BIAS_STATE_O),
	.TRANSMIT_STUCK_LOW_BLOCK_O(TRANSMIT_STUCK_LOW_BLOCK_O)
);
`default_nettype wire

// File: bench/tb_top.sv
/*
 * self-checking bench for the bus-bias block and its controller model.
 * assumes short filter and silence counts set at the instance.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		can_bias_pkg::op_mode_e    mode;
		can_bias_pkg::supply_s     sup;
		logic                      dom;
		logic [7:0]                hold;
		can_bias_pkg::bias_state_e st;
		can_bias_pkg::bus_drive_s  drv;
	} row_s;
	localparam can_bias_pkg::op_mode_e    nrm = can_bias_pkg::MODE_NORMAL;
	localparam can_bias_pkg::op_mode_e    sil = can_bias_pkg::MODE_SILENT;
	localparam can_bias_pkg::op_mode_e    stb = can_bias_pkg::MODE_STANDBY;
	localparam can_bias_pkg::op_mode_e    slp = can_bias_pkg::MODE_SLEEP;
	localparam can_bias_pkg::op_mode_e    gts = can_bias_pkg::MODE_GOTOSLEEP;
	localparam can_bias_pkg::bias_state_e b_off = can_bias_pkg::BIAS_OFF;
	localparam can_bias_pkg::bias_state_e b_ina = can_bias_pkg::BIAS_AUTO_INACTIVE;
	localparam can_bias_pkg::bias_state_e b_aac = can_bias_pkg::BIAS_AUTO_ACTIVE;
	localparam can_bias_pkg::bias_state_e b_act = can_bias_pkg::BIAS_ACTIVE;
	// mode, supplies, dominant request, cycles held, state, drive
	localparam row_s rows [15] = '{
		'{stb, 6'h13, 1'b0, 8'h08, b_ina, 3'h1}, '{nrm, 6'h13, 1'b0, 8'h08, b_act, 3'h2},
		'{nrm, 6'h13, 1'b1, 8'h08, b_act, 3'h6}, '{sil, 6'h13, 1'b1, 8'h08, b_act, 3'h2},
		'{nrm, 6'h19, 1'b0, 8'h08, b_aac, 3'h2}, '{nrm, 6'h13, 1'b0, 8'h08, b_act, 3'h2},
		'{stb, 6'h13, 1'b0, 8'h08, b_aac, 3'h2}, '{stb, 6'h13, 1'b0, 8'h3c, b_ina, 3'h1},
		'{nrm, 6'h16, 1'b0, 8'h08, b_aac, 3'h2}, '{nrm, 6'h13, 1'b0, 8'h3c, b_act, 3'h2},
		'{stb, 6'h13, 1'b0, 8'h08, b_ina, 3'h1}, '{stb, 6'h23, 1'b0, 8'h08, b_off, 3'h0},
		'{stb, 6'h13, 1'b0, 8'h08, b_ina, 3'h1}, '{slp, 6'h13, 1'b0, 8'h08, b_ina, 3'h1},
		'{gts, 6'h13, 1'b0, 8'h08, b_ina, 3'h1}};
	logic                      clk = 1'b0;
	logic                      rst = 1'b1;
	can_bias_pkg::op_mode_e    mode = stb;
	can_bias_pkg::supply_s     sup = 6'h13;
	logic                      dom = 1'b0;
	logic                      stall = 1'b0;
	logic                      bus_ext = 1'b0;
	logic                      wake = 1'b0;
	logic                      wclr = 1'b0;
	logic                      txd, acc, rxd, rdy, pend, lwe, rwp, blk, bus_dom;
	can_bias_pkg::bus_drive_s  drv;
	can_bias_pkg::bias_state_e st;
	int                        fails = 0, num_checks = 0, lw = 0, rw = 0, lw0 = 0, rw0 = 0;
	assign bus_dom = bus_ext | ~txd;
	always #5 clk = ~clk;
	can_ctrl_model can_ctrl_model_i (.clk_i(clk), .rst_i(rst), .dom_req_i(dom),
		.stall_i(stall), .txd_o(txd), .accept_o(acc));
	can_bias_ctrl #(.FILTER_CYCLES(10), .SILENCE_CYCLES(50)) can_bias_ctrl_i (
		.MCLK_I(clk), .RST_I(rst), .MODE_I(mode), .SUPPLY_I(sup), .TXD_I(txd), .RXD_O(rxd),
		.RXD_READY_O(rdy), .RXD_ACCEPT_I(acc), .BUS_DOMINANT_I(bus_dom), .BUS_DRIVE_O(drv),
		.WAKE_I(wake), .WAKE_CLEAR_I(wclr), .WAKE_PENDING_O(pend), .LOCAL_WAKE_EVENT_O(lwe),
		.REMOTE_WAKE_PATTERN_O(rwp), .BIAS_STATE_O(st), .TRANSMIT_STUCK_LOW_BLOCK_O(blk));
	always @(posedge clk) begin
		if (lwe === 1'b1) lw++;
		if (rwp === 1'b1) rw++;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		$display("watchdog ran out");
		wrap_up;
	end
	initial begin
		cyc(20);
		rst <= 1'b0;
		foreach (rows[i]) begin
			mode <= rows[i].mode;
			sup  <= rows[i].sup;
			dom  <= rows[i].dom;
			cyc(rows[i].hold);
			chk("bias state", 8'(st), 8'(rows[i].st));
			chk("bus drive", 8'(drv), 8'(rows[i].drv));
		end
		done("table");
		mode <= stb;
		dom <= 1'b1;
		cyc(8);
		mode <= nrm;
		cyc(10);
		chk("stuck block", 8'(blk), 8'h01);
		chk("drive while blocked", 8'(drv), 8'h02);
		dom <= 1'b0;
		cyc(6);
		chk("stuck block released", 8'(blk), 8'h00);
		stall <= 1'b1;
		cyc(40);
		chk("receive ready while stalled", 8'(rdy), 8'h01);
		stall <= 1'b0;
		cyc(40);
		chk("receive idle level", 8'(rxd), 8'h01);
		done("stuck low and buffer");
		mode <= slp;
		cyc(10);
		lw0 = lw;
		wake <= 1'b1;
		cyc(20);
		chk("local events rising", 8'(lw - lw0), 8'h01);
		wake <= 1'b0;
		cyc(20);
		chk("local events falling", 8'(lw - lw0), 8'h02);
		chk("wake pending", 8'(pend), 8'h01);
		mode <= stb;
		cyc(80);
		chk("receive with wake pending", 8'(rxd), 8'h00);
		wclr <= 1'b1;
		cyc(1);
		wclr <= 1'b0;
		cyc(80);
		chk("receive after clear", 8'(rxd), 8'h01);
		done("local wake");
		mode <= nrm;
		cyc(20);
		lw0 = lw;
		wake <= 1'b1;
		cyc(20);
		wake <= 1'b0;
		cyc(20);
		chk("local events in normal", 8'(lw - lw0), 8'h00);
		done("no wake in normal");
		mode <= slp;
		rw0 = rw;
		cyc(60);
		bus_ext <= 1'b1;
		cyc(15);
		bus_ext <= 1'b0;
		cyc(15);
		bus_ext <= 1'b1;
		cyc(15);
		bus_ext <= 1'b0;
		cyc(5);
		chk("remote patterns", 8'(rw - rw0), 8'h01);
		chk("bias after remote wake", 8'(st), 8'(b_aac));
		done("remote wake");
		rst <= 1'b1;
		cyc(3);
		chk("bias in reset", 8'(st), 8'(b_off));
		chk("receive in reset", 8'(rxd), 8'h01);
		chk("receive ready in reset", 8'(rdy), 8'h00);
		rst <= 1'b0;
		cyc(2);
		chk("bias after reset", 8'(st), 8'(b_ina));
		done("second reset");
		wrap_up;
	end
endmodule
`default_nettype wire
